// ### rtl/rtcl_regs.svh
// rtcl_regs.svh: constants of the run-time clock and fault logger
`ifndef RTCL_REGS_SVH
`define RTCL_REGS_SVH
`define RTCL_NV_W        96
`define RTCL_AW          5
`define RTCL_NV_DEPTH    32
`define RTCL_RAILS       12
`define RTCL_FAULTS      12
`define RTCL_ADDR_CLK    5'h00
`define RTCL_ADDR_RCNT   5'h01
`define RTCL_ADDR_PEAK   5'h02
`define RTCL_ADDR_FAULT  5'h0E
`define RTCL_MS_PER_DAY  32'h05265C00
`define RTCL_CLK_NS      10
`define RTCL_MS_NS       1000000
`define RTCL_S_NS        1000000000
`define RTCL_PEAK_WIN_S  30
`define RTCL_W_MS_LSB    0
`define RTCL_W_DAY_LSB   32
`define RTCL_W_VOLT_LSB  64
`define RTCL_W_TYPE_LSB  76
`define RTCL_W_RAIL_LSB  80
`endif

// ### rtl/rtcl_pkg.sv
// rtcl_pkg.sv: types and helpers of the run-time clock and fault logger
`include "rtcl_regs.svh"
package rtcl_pkg;
  typedef logic [`RTCL_NV_W-1:0] rtcl_word_t;
  typedef logic [`RTCL_AW-1:0]   rtcl_addr_t;
  typedef enum logic [1:0] {ST_BOOT, ST_RUN, ST_FLUSH, ST_DONE} rtcl_state_t;

  function automatic logic [4:0] rtcl_lowest(input logic [31:0] v);
    logic [4:0] idx;
    idx = 5'h00;
    for (int i = 31; i >= 0; i--) begin
      if (v[i]) begin
        idx = 5'(i);
      end
    end
    return idx;
  endfunction : rtcl_lowest

  function automatic rtcl_word_t rtcl_pack(input logic [3:0]  rail,
                                           input logic [3:0]  ftype,
                                           input logic [11:0] volt,
                                           input logic [31:0] ms,
                                           input logic [31:0] day);
    rtcl_word_t w;
    w                            = '0;
    w[`RTCL_W_MS_LSB +: 32]      = ms;
    w[`RTCL_W_DAY_LSB +: 32]     = day;
    w[`RTCL_W_VOLT_LSB +: 12]    = volt;
    w[`RTCL_W_TYPE_LSB +: 4]     = ftype;
    w[`RTCL_W_RAIL_LSB +: 4]     = rail;
    return w;
  endfunction : rtcl_pack
endpackage : rtcl_pkg

// ### rtl/rtcl_nv_if.sv
// rtcl_nv_if.sv: link between the logger and its nonvolatile store
`timescale 1ns/1ns
interface rtcl_nv_if;
  import rtcl_pkg::*;
  logic       wr_en;
  rtcl_addr_t wr_addr;
  rtcl_word_t wr_data;
  rtcl_addr_t rd_addr;
  rtcl_word_t rd_data;
  rtcl_word_t clk_word;
  rtcl_word_t cnt_word;
  modport ctrl (output wr_en, wr_addr, wr_data, rd_addr,
                input  rd_data, clk_word, cnt_word);
  modport mem  (input  wr_en, wr_addr, wr_data, rd_addr,
                output rd_data, clk_word, cnt_word);
endinterface : rtcl_nv_if

// ### rtl/rtcl_nvm.sv
// rtcl_nvm.sv: flash image, one word written per cycle
`timescale 1ns/1ns
`include "rtcl_regs.svh"
module rtcl_nvm import rtcl_pkg::*; (
  // clock
  input wire logic clk_sys_in,
  // store port
  rtcl_nv_if.mem   nv
);
  rtcl_word_t flash [`RTCL_NV_DEPTH];

  // erased image at power-up; no reset so contents outlive restarts
  initial begin
    for (int i = 0; i < `RTCL_NV_DEPTH; i++) begin
      flash[i] = '0;
    end
  end

  always @(posedge clk_sys_in) begin
    if (nv.wr_en) begin
      flash[nv.wr_addr] <= nv.wr_data;
    end
  end

  assign nv.rd_data  = flash[nv.rd_addr];
  assign nv.clk_word = flash[`RTCL_ADDR_CLK];
  assign nv.cnt_word = flash[`RTCL_ADDR_RCNT];
endmodule : rtcl_nvm

// ### rtl/rtcl_peak.sv
// rtcl_peak.sv: per-rail peak tracking with a settling window
`timescale 1ns/1ns
`include "rtcl_regs.svh"
module rtcl_peak import rtcl_pkg::*; #(
  parameter longint unsigned WIN_CYC = 64'd3000000000
) (
  // clock and reset
  input  wire logic        clk_sys_in,
  input  wire logic        rst_n_in,
  // measurement samples
  input  wire logic        samp_valid_in,
  input  wire logic [3:0]  samp_rail_in,
  input  wire logic [11:0] samp_volt_in,
  // peak ready to log, taken in the same cycle
  output logic             commit_out,
  output logic [3:0]       commit_rail_out,
  output logic [11:0]      commit_volt_out
);
  localparam logic [31:0] WIN_LAST = 32'(WIN_CYC - 64'd1);

  logic [`RTCL_RAILS-1:0] pend_vec;
  logic [11:0]            wmax_vec [`RTCL_RAILS];
  wire  [4:0]             sel = rtcl_lowest({20'h00000, pend_vec});

  assign commit_out      = |pend_vec;
  assign commit_rail_out = sel[3:0];
  assign commit_volt_out = wmax_vec[sel[3:0]];

  ////////////////////////////////////////////////////////////////////////////
  for (genvar r = 0; r < `RTCL_RAILS; r++) begin : g_rail
    logic [31:0] timer;
    logic        run;
    logic        pend;
    logic [11:0] wmax;
    logic [11:0] logged;
    wire hit    = samp_valid_in && samp_rail_in == 4'(r);
    wire start  = hit && !run && !pend && samp_volt_in > logged;
    wire expire = run && timer == WIN_LAST;
    wire ack    = commit_out && sel == 5'(r);

    assign pend_vec[r] = pend;
    assign wmax_vec[r] = wmax;

    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
        timer  <= 32'h00000000;
        run    <= 1'b0;
        pend   <= 1'b0;
        wmax   <= 12'h000;
        logged <= 12'h000;
      end else begin
        if (start) begin
          run   <= 1'b1;
          timer <= 32'h00000000;
          wmax  <= samp_volt_in;
        end else if (expire) begin
          run  <= 1'b0;
          pend <= 1'b1;
        end else if (run) begin
          timer <= timer + 32'h00000001;
          if (hit && samp_volt_in > wmax) begin
            wmax <= samp_volt_in;
          end
        end
        if (ack) begin
          pend   <= 1'b0;
          logged <= wmax;
        end
      end
    end

    a_win_start: assert property (
      @(posedge clk_sys_in) disable iff (!rst_n_in)
      start |=> run && timer == 32'h00000000 && wmax == $past(samp_volt_in))
      else $error("peak window did not open");
  end
endmodule : rtcl_peak

// ### rtl/rtcl_top.sv
// rtcl_top.sv: run-time clock with fault, peak and reset-count logging
`timescale 1ns/1ns
`include "rtcl_regs.svh"
module rtcl_top import rtcl_pkg::*; #(
  parameter int unsigned     MS_CYC       = `RTCL_MS_NS / `RTCL_CLK_NS,
  parameter longint unsigned PEAK_WIN_CYC =
    longint'(`RTCL_PEAK_WIN_S) * `RTCL_S_NS / `RTCL_CLK_NS
) (
  // clock and reset
  input  wire logic        clk_sys_in,
  input  wire logic        rst_n_in,
  // boot, configuration and supply monitor
  input  wire logic        boot_done_in,
  input  wire logic        brownout_en_in,
  input  wire logic        brownout_in,
  // host commands
  input  wire logic        time_wr_in,
  input  wire logic [31:0] time_ms_in,
  input  wire logic [31:0] time_day_in,
  input  wire logic        save_all_in,
  input  wire logic        clr_resets_in,
  // measurements and faults
  input  wire logic        samp_valid_in,
  input  wire logic [3:0]  samp_rail_in,
  input  wire logic [11:0] samp_volt_in,
  input  wire logic        fault_valid_in,
  input  wire logic [3:0]  fault_rail_in,
  input  wire logic [3:0]  fault_type_in,
  // log read-back
  input  wire logic        rd_en_in,
  input  wire logic [4:0]  rd_addr_in,
  output logic             rd_valid_out,
  output logic [95:0]      rd_data_out,
  // status
  output logic [31:0]      rtc_ms_out,
  output logic [31:0]      rtc_day_out,
  output logic [31:0]      resets_out,
  output logic             bo_mode_out,
  output logic             saving_out,
  output logic             save_done_out
);
  localparam logic [31:0] MS_LAST  = 32'(MS_CYC - 1);
  localparam logic [31:0] DAY_LAST = `RTCL_MS_PER_DAY - 32'h00000001;

  rtcl_nv_if   nv ();
  rtcl_state_t state;
  rtcl_state_t next_state;
  logic        bo_mode;
  logic [31:0] ms;
  logic [31:0] day;
  logic [31:0] div;
  logic [31:0] rst_count;
  logic [3:0]  fault_ptr;
  logic [31:0] dirty;
  logic [31:0] valid;
  logic [11:0] last_v [`RTCL_RAILS];
  rtcl_word_t  sram [`RTCL_NV_DEPTH];
  logic        commit;
  logic [3:0]  commit_rail;
  logic [11:0] commit_volt;

  ////////////////////////////////////////////////////////////////////////////
  // event decode
  wire run_st    = state == ST_RUN;
  wire boot_end  = state == ST_BOOT && boot_done_in;
  wire restore   = boot_end && brownout_en_in;
  wire host_wr   = time_wr_in && run_st;
  wire tick      = run_st && div == MS_LAST;
  wire day_end   = ms == DAY_LAST;
  wire save_ok   = save_all_in && run_st;
  wire clr_ok    = clr_resets_in && run_st;
  wire bo_start  = brownout_in && bo_mode && run_st;
  wire fault_ok  = fault_valid_in && run_st &&
                   fault_rail_in < 4'(`RTCL_RAILS);
  wire samp_ok   = samp_valid_in && samp_rail_in < 4'(`RTCL_RAILS);
  wire cnt_wr    = boot_end || clr_ok;
  wire clk_snap  = save_ok || bo_start;
  wire [4:0] peak_addr  = `RTCL_ADDR_PEAK + {1'b0, commit_rail};
  wire [4:0] fault_addr = `RTCL_ADDR_FAULT + {1'b0, fault_ptr};
  wire [31:0] next_count = boot_end ? nv.cnt_word[31:0] + 32'h00000001
                                    : 32'h00000000;

  ////////////////////////////////////////////////////////////////////////////
  // clock counts
  wire [31:0] next_ms =
    restore ? nv.clk_word[`RTCL_W_MS_LSB +: 32] :
    host_wr ? time_ms_in :
    tick    ? (day_end ? 32'h00000000 : ms + 32'h00000001) : ms;
  wire [31:0] next_day =
    restore ? nv.clk_word[`RTCL_W_DAY_LSB +: 32] :
    host_wr ? time_day_in :
    (tick && day_end) ? day + 32'h00000001 : day;
  // boot time is never counted: divider only runs in the run state
  wire [31:0] next_div = (!run_st || host_wr || tick) ? 32'h00000000
                                                      : div + 32'h00000001;

  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ms  <= 32'h00000000;
      day <= 32'h00000000;
      div <= 32'h00000000;
    end else begin
      ms  <= next_ms;
      day <= next_day;
      div <= next_div;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // operating state
  always_comb begin
    next_state = state;
    case (state)
      ST_BOOT:  if (boot_done_in) next_state = ST_RUN;
      ST_RUN:   if (bo_start) next_state = ST_FLUSH;
      ST_FLUSH: if (dirty == 32'h00000000) next_state = ST_DONE;
      ST_DONE:  next_state = ST_DONE;
      default:  next_state = ST_BOOT;
    endcase
  end

  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state   <= ST_BOOT;
      bo_mode <= 1'b0;
    end else begin
      state <= next_state;
      if (boot_end) begin
        bo_mode <= brownout_en_in;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // reset total, fault slot, last voltage per rail
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rst_count <= 32'h00000000;
      fault_ptr <= 4'h0;
      for (int i = 0; i < `RTCL_RAILS; i++) begin
        last_v[i] <= 12'h000;
      end
    end else begin
      if (cnt_wr) begin
        rst_count <= next_count;
      end
      if (fault_ok) begin // oldest entry is overwritten once full
        fault_ptr <= (fault_ptr == 4'(`RTCL_FAULTS - 1)) ? 4'h0
                                                         : fault_ptr + 4'h1;
      end
      if (samp_ok) begin
        last_v[samp_rail_in] <= samp_volt_in;
      end
    end
  end

  rtcl_peak #(
    .WIN_CYC         (PEAK_WIN_CYC)
  ) u_peak (
    .clk_sys_in      (clk_sys_in),
    .rst_n_in        (rst_n_in),
    .samp_valid_in   (samp_ok),
    .samp_rail_in    (samp_rail_in),
    .samp_volt_in    (samp_volt_in),
    .commit_out      (commit),
    .commit_rail_out (commit_rail),
    .commit_volt_out (commit_volt)
  );

  ////////////////////////////////////////////////////////////////////////////
  // SRAM log image; no reset, only entries marked valid, plus the clock entry at brownout, are ever flushed
  always_ff @(posedge clk_sys_in) begin
    if (clk_snap) begin
      sram[`RTCL_ADDR_CLK] <= rtcl_pack(4'h0, 4'h0, 12'h000, ms, day);
    end
    if (cnt_wr) begin
      sram[`RTCL_ADDR_RCNT] <= rtcl_pack(4'h0, 4'h0, 12'h000,
                                         next_count, 32'h00000000);
    end
    if (commit) begin
      sram[peak_addr] <= rtcl_pack(4'h0, 4'h0, commit_volt,
                                   32'h00000000, 32'h00000000);
    end
    if (fault_ok) begin
      sram[fault_addr] <= rtcl_pack(fault_rail_in, fault_type_in,
                                    last_v[fault_rail_in], ms, day);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // flash writer: lowest dirty entry first, a set beats a same-cycle clear
  wire [31:0] set_norm = (save_ok  ? 32'h00000001 << `RTCL_ADDR_CLK  : '0) |
                         (cnt_wr   ? 32'h00000001 << `RTCL_ADDR_RCNT : '0) |
                         (commit   ? 32'h00000001 << peak_addr       : '0) |
                         (fault_ok ? 32'h00000001 << fault_addr      : '0);
  wire [31:0] set_bo   = bo_start ? (valid | (32'h00000001 << `RTCL_ADDR_CLK))
                                  : 32'h00000000;
  wire        wr_allow = (run_st && !bo_mode) || state == ST_FLUSH;
  wire [4:0]  wr_idx   = rtcl_lowest(dirty);
  wire        wr_go    = wr_allow && dirty != 32'h00000000;
  wire [31:0] wr_clr   = wr_go ? 32'h00000001 << wr_idx : 32'h00000000;

  assign nv.wr_en   = wr_go;
  assign nv.wr_addr = wr_idx;
  assign nv.wr_data = sram[wr_idx];
  assign nv.rd_addr = rd_addr_in;

  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      dirty <= 32'h00000000;
      valid <= 32'h00000000;
    end else begin
      dirty <= (dirty & ~wr_clr) | set_norm | set_bo;
      valid <= valid | set_norm;
    end
  end

  rtcl_nvm u_nvm (
    .clk_sys_in (clk_sys_in),
    .nv         (nv)
  );

  ////////////////////////////////////////////////////////////////////////////
  // read-back and status
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rd_valid_out <= 1'b0;
      rd_data_out  <= 96'h0;
    end else begin
      rd_valid_out <= rd_en_in;
      if (rd_en_in) begin
        rd_data_out <= nv.rd_data;
      end
    end
  end

  assign rtc_ms_out    = ms;
  assign rtc_day_out   = day;
  assign resets_out    = rst_count;
  assign bo_mode_out   = bo_mode;
  assign saving_out    = state == ST_FLUSH;
  assign save_done_out = state == ST_DONE;

  ////////////////////////////////////////////////////////////////////////////
  // checks share one clock, and all are off while reset is low
  default clocking cb @(posedge clk_sys_in);
  endclocking
  default disable iff (!rst_n_in);

  a_day_wrap: assert property (
    tick && day_end && !host_wr |=> ms == 32'h0 && day == $past(day) + 32'h1)
    else $error("day rollover wrong");
  a_ms_step: assert property (
    tick && !day_end && !host_wr |=> ms == $past(ms) + 32'h1 && $stable(day))
    else $error("millisecond step wrong");
  a_host_set: assert property (
    host_wr |=> ms == $past(time_ms_in) && day == $past(time_day_in))
    else $error("host time write lost");
  a_boot_zero: assert property (
    state == ST_BOOT |-> ms == 32'h0 && day == 32'h0 && !bo_mode)
    else $error("clock not zero during boot");
  a_restore_clk: assert property (
    restore |=> ms == $past(nv.clk_word[31:0]) &&
    day == $past(nv.clk_word[63:32]))
    else $error("preserved clock not restored");
  a_no_restore: assert property (
    boot_end && !brownout_en_in |=> ms == 32'h0 && day == 32'h0)
    else $error("clock kept without brownout mode");
  a_save_clock: assert property (
    save_ok && !bo_mode |=> nv.wr_en && nv.wr_addr == `RTCL_ADDR_CLK &&
    nv.wr_data[31:0] == $past(ms))
    else $error("save-all did not store clock");
  a_bo_quiet: assert property (
    bo_mode && state == ST_RUN |-> !nv.wr_en)
    else $error("flash written in brownout mode");
  a_bo_flush: assert property (
    bo_start |=> state == ST_FLUSH && nv.wr_en && dirty[0])
    else $error("brownout did not start save");
  a_flush_all: assert property (
    state == ST_FLUSH && dirty == 32'h0 |=> state == ST_DONE && !nv.wr_en)
    else $error("flush did not finish");
  a_fault_stamp: assert property (
    fault_ok |=> sram[$past(fault_addr)][31:0] == $past(ms) &&
    sram[$past(fault_addr)][63:32] == $past(day))
    else $error("fault timestamp wrong");
  a_fault_fields: assert property (
    fault_ok |=> sram[$past(fault_addr)][83:76] ==
    {$past(fault_rail_in), $past(fault_type_in)})
    else $error("fault record fields wrong");
  a_count_clear: assert property (
    clr_ok |=> resets_out == 32'h0 && dirty[1])
    else $error("reset total not cleared");
  a_peak_log: assert property (
    commit |=> dirty[$past(peak_addr)])
    else $error("peak not queued for flash");
endmodule : rtcl_top

// ### dv/rtcl_host.sv
// rtcl_host.sv: host model for clock writes, commands and log reads
`timescale 1ns/1ns
module rtcl_host (
  // clock
  input  wire logic        clk_sys_in,
  // commands
  output logic             time_wr_out,
  output logic [31:0]      time_ms_out,
  output logic [31:0]      time_day_out,
  output logic             save_all_out,
  output logic             clr_resets_out,
  // log reads
  output logic             rd_en_out,
  output logic [4:0]       rd_addr_out,
  input  wire logic        rd_valid_in,
  input  wire logic [95:0] rd_data_in
);
  initial begin
    time_wr_out    = 1'b0;
    time_ms_out    = 32'h0;
    time_day_out   = 32'h0;
    save_all_out   = 1'b0;
    clr_resets_out = 1'b0;
    rd_en_out      = 1'b0;
    rd_addr_out    = 5'h00;
  end
  // calendar to milliseconds is done here, never in the device
  function automatic logic [31:0] cal_ms(input int h, m, s, f);
    return 32'(((h * 60 + m) * 60 + s) * 1000 + f);
  endfunction : cal_ms
  task automatic set_time(input logic [31:0] day, ms);
    @(negedge clk_sys_in);
    time_wr_out  = 1'b1;
    time_ms_out  = ms;
    time_day_out = day;
    @(negedge clk_sys_in);
    time_wr_out  = 1'b0;
    // inverted idle data so a late capture cannot look right
    time_ms_out  = ~ms;
    time_day_out = ~day;
  endtask : set_time
  task automatic cmd(input logic clr);
    @(negedge clk_sys_in);
    save_all_out   = ~clr;
    clr_resets_out = clr;
    @(negedge clk_sys_in);
    save_all_out   = 1'b0;
    clr_resets_out = 1'b0;
  endtask : cmd
  task automatic read(input logic [4:0] a, output logic [95:0] d);
    int n;
    @(negedge clk_sys_in);
    rd_en_out   = 1'b1;
    rd_addr_out = a;
    @(negedge clk_sys_in);
    rd_en_out   = 1'b0;
    rd_addr_out = ~a;
    n = 0;
    while (rd_valid_in !== 1'b1 && n < 4) begin
      @(negedge clk_sys_in);
      n++;
    end
    d = (rd_valid_in === 1'b1) ? rd_data_in : 'x;
  endtask : read
endmodule : rtcl_host

// ### dv/test_rtcl_top.sv
// test_rtcl_top.sv: self-checking bench of the run-time clock logger
`timescale 1ns/1ns
module test_rtcl_top;
  localparam int     MS = 4;
  localparam longint PW = 20;
  logic        clk, rst_n, boot_done, bo_en, bo;
  logic        samp_v, fault_v;
  logic [3:0]  samp_rail, fault_rail, fault_type;
  logic [11:0] samp_volt;
  logic        t_wr, save_all, clr_rst, rd_en, rd_valid, bo_mode;
  logic [31:0] t_ms, t_day, rtc_ms, rtc_day, resets;
  logic [4:0]  rd_addr;
  logic [95:0] rd_data, d;
  logic [63:0] saved;
  logic        saving, save_done;
  int          errors, comparisons;

  rtcl_top #(.MS_CYC(MS), .PEAK_WIN_CYC(PW)) i_rtcl_top (
    .clk_sys_in(clk), .rst_n_in(rst_n), .boot_done_in(boot_done),
    .brownout_en_in(bo_en), .brownout_in(bo), .time_wr_in(t_wr),
    .time_ms_in(t_ms), .time_day_in(t_day), .save_all_in(save_all),
    .clr_resets_in(clr_rst), .samp_valid_in(samp_v),
    .samp_rail_in(samp_rail), .samp_volt_in(samp_volt),
    .fault_valid_in(fault_v), .fault_rail_in(fault_rail),
    .fault_type_in(fault_type), .rd_en_in(rd_en), .rd_addr_in(rd_addr),
    .rd_valid_out(rd_valid), .rd_data_out(rd_data), .rtc_ms_out(rtc_ms),
    .rtc_day_out(rtc_day), .resets_out(resets), .bo_mode_out(bo_mode),
    .saving_out(saving), .save_done_out(save_done));
  rtcl_host i_rtcl_host (
    .clk_sys_in(clk), .time_wr_out(t_wr), .time_ms_out(t_ms),
    .time_day_out(t_day), .save_all_out(save_all),
    .clr_resets_out(clr_rst), .rd_en_out(rd_en), .rd_addr_out(rd_addr),
    .rd_valid_in(rd_valid), .rd_data_in(rd_data));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  ////////////////////////////////////////////////////////////////////////
  task automatic final_report();
    $display("errors=%0d comparisons=%0d", errors, comparisons);
    if (errors == 0 && comparisons > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : final_report
  task automatic chk(input logic [95:0] got, exp, input string msg);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("Error at %0t: %s", $time, msg);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask : cyc
  task automatic do_reset(input logic mode);
    @(negedge clk);
    rst_n     = 1'b0;
    boot_done = 1'b0;
    bo_en     = mode;
    cyc(6);
    rst_n = 1'b1;
    cyc(3 * MS);
    chk(rtc_ms, 32'h0, "clock moved during boot");
    boot_done = 1'b1;
    cyc(1);
    boot_done = 1'b0;
    cyc(1);
  endtask : do_reset
  task automatic samp(input logic [3:0] r, input logic [11:0] v);
    samp_v    = 1'b1;
    samp_rail = r;
    samp_volt = v;
    cyc(1);
    samp_v = 1'b0;
  endtask : samp

  ////////////////////////////////////////////////////////////////////////
  task automatic t_clock();
    do_reset(1'b0);
    chk({rtc_day, rtc_ms}, 64'h0, "clock after restart");
    chk(bo_mode, 1'b0, "brownout mode on by default");
    chk(resets, 32'h1, "reset total");
    bo = 1'b1;
    cyc(1);
    bo = 1'b0;
    cyc(2);
    chk(saving, 1'b0, "brownout acted while disabled");
    i_rtcl_host.set_time(32'hFFFFFFFF, i_rtcl_host.cal_ms(23, 59, 59, 999));
    cyc(1);
    chk({rtc_day, rtc_ms}, {32'hFFFFFFFF, 32'h05265BFF}, "write");
    cyc(MS + 1);
    chk({rtc_day, rtc_ms}, 64'h0, "day rollover");
  endtask : t_clock
  task automatic t_save();
    saved = {32'h12, 32'h345};
    i_rtcl_host.set_time(32'h12, 32'h345);
    i_rtcl_host.cmd(1'b0);
    cyc(6);
    i_rtcl_host.read(5'h00, d);
    chk(d[63:0], saved, "saved clock");
  endtask : t_save
  task automatic t_fault();
    samp(4'h3, 12'h456);
    i_rtcl_host.set_time(32'h21, 32'h99);
    fault_v    = 1'b1;
    fault_rail = 4'h3;
    fault_type = 4'h5;
    cyc(1);
    fault_v = 1'b0;
    cyc(6);
    i_rtcl_host.read(5'h0E, d);
    chk(d, {12'h0,4'h3,4'h5,12'h456,32'h21,32'h99}, "fault");
  endtask : t_fault
  task automatic t_peak();
    samp(4'h2, 12'h100);
    samp(4'h2, 12'h300);
    samp(4'h2, 12'h200);
    i_rtcl_host.read(5'h04, d);
    chk(d[75:64], 12'h000, "peak stored inside window");
    cyc(int'(PW) + 4);
    i_rtcl_host.read(5'h04, d);
    chk(d[75:64], 12'h300, "window peak");
  endtask : t_peak
  task automatic t_clear();
    i_rtcl_host.cmd(1'b1);
    cyc(2);
    chk(resets, 32'h0, "reset total not cleared");
    cyc(4);
    i_rtcl_host.read(5'h01, d);
    chk(d[31:0], 32'h0, "stored reset total");
    do_reset(1'b0);
    chk(resets, 32'h1, "reset total after restart");
    chk({rtc_day, rtc_ms}, 64'h0, "clock kept without brownout");
    i_rtcl_host.read(5'h0E, d);
    chk(d[83:80], 4'h3, "fault lost over restart");
  endtask : t_clear
  task automatic t_brownout();
    int n;
    do_reset(1'b1);
    chk(bo_mode, 1'b1, "brownout mode");
    chk({rtc_day, rtc_ms}, saved, "clock not preserved");
    chk(resets, 32'h2, "reset total");
    i_rtcl_host.cmd(1'b0);
    cyc(6);
    i_rtcl_host.read(5'h00, d);
    chk(d[63:0], saved, "flash written in normal run");
    i_rtcl_host.set_time(32'h77, 32'h55);
    bo = 1'b1;
    cyc(1);
    bo = 1'b0;
    chk(saving, 1'b1, "brownout did not start save");
    n = 0;
    while (save_done !== 1'b1 && n < 100) begin
      cyc(1);
      n++;
    end
    chk({saving, save_done}, 2'b01, "save did not finish");
    i_rtcl_host.read(5'h00, d);
    chk(d[63:0], {32'h77, 32'h55}, "clock flush");
  endtask : t_brownout

  ////////////////////////////////////////////////////////////////////////
  initial begin
    errors      = 0;
    comparisons = 0;
    rst_n       = 1'b0;
    boot_done   = 1'b0;
    bo_en       = 1'b0;
    bo          = 1'b0;
    samp_v      = 1'b0;
    samp_rail   = 4'h0;
    samp_volt   = 12'h000;
    fault_v     = 1'b0;
    fault_rail  = 4'h0;
    fault_type  = 4'h0;
    saved       = 64'h0;
    t_clock();
    t_save();
    t_fault();
    t_peak();
    t_clear();
    t_brownout();
    final_report();
  end
  // whole run is under 200 cycles; this is far beyond it
  initial begin
    #50000;
    errors++;
    $display("Error at %0t: watchdog expired", $time);
    final_report();
  end
endmodule : test_rtcl_top
